//--- src/pesd_map.svh
// register offsets, field positions, reset values and event codes of the
// performance event select decoder; included by the package and the top module
`ifndef PESD_MAP_SVH
`define PESD_MAP_SVH

// byte offsets, one aligned 32-bit word each
`define PESD_OFS_EVT_BASE   8'h00
`define PESD_OFS_CFG_BASE   8'h20
`define PESD_OFS_CNT_BASE   8'h30

// event register fields
`define PESD_EVT_SEL7_HI    31
`define PESD_EVT_SEL6_HI    30
`define PESD_EVT_SEL_LO     25
`define PESD_EVT_MASK_LO    9
`define PESD_EVT_WMASK      32'hfffffe00
`define PESD_EVT_RESET      32'h00000000

// configuration register fields and counter reset value
`define PESD_CFG_SEL_HI     15
`define PESD_CFG_SEL_LO     13
`define PESD_CFG_EN_BIT     12
`define PESD_CFG_WMASK      32'h0000f000
`define PESD_CFG_RESET      32'h00000000
`define PESD_CNT_RESET      32'h00000000

// event select codes
`define PESD_CODE_ACTIVE    7'h13
`define PESD_CODE_XFER      7'h05
`define PESD_CODE_QWRITE    7'h09
`define PESD_CODE_MISPRED   6'h05
`define PESD_CODE_RETIRED   6'h04

`endif

//--- src/pesd_pkg.sv
// types of the performance event select decoder
// assumes pesd_map.svh is on the include path
`include "pesd_map.svh"

package pesd_pkg;

  // configuration select code: which event-register family feeds a counter
  typedef enum logic [2:0] {
    PESD_SRC_SEQ = 3'h0,
    PESD_SRC_BR  = 3'h2,
    PESD_SRC_PWR = 3'h6
  } pesd_src_t;

  // event register slots in address order
  typedef enum logic [2:0] {
    PESD_EVT_SEQ_A = 3'h0,
    PESD_EVT_SEQ_B = 3'h1,
    PESD_EVT_BR_A  = 3'h2,
    PESD_EVT_BR_B  = 3'h3,
    PESD_EVT_PWR_A = 3'h4,
    PESD_EVT_PWR_B = 3'h5
  } pesd_evt_t;

  typedef logic [7:0]  pesd_addr_t;
  typedef logic [31:0] pesd_word_t;

endpackage

//--- src/pesd_top.sv
// performance event select decoder with counters 4..7
// assumes event inputs come from pipeline logic on clk_sys_in; software reaches
// the registers over a plain strobe port with read data one cycle later
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pesd_map.svh"

module pesd_top #(
  parameter int NUM_CNT = 4,
  parameter int NUM_EVT = 6
) (
  // clock and reset
  input  wire  logic                 clk_sys_in,
  input  wire  logic                 rstn_in,
  // register port
  input  wire  pesd_pkg::pesd_addr_t reg_addr_in,
  input  wire  pesd_pkg::pesd_word_t reg_wdata_in,
  input  wire  logic                 reg_wr_in,
  input  wire  logic                 reg_rd_in,
  output var   pesd_pkg::pesd_word_t reg_rdata_out,
  // pipeline event sources
  input  wire  logic                 proc_active_in,
  input  wire  logic                 delivery_switch_event_in,
  input  wire  logic                 uopq_write_in,
  input  wire  logic [2:0]           uopq_src_in,
  input  wire  logic                 br_retire_in,
  input  wire  logic                 br_mispred_in,
  input  wire  logic [3:0]           br_type_in,
  // per-counter increment pulses
  output var   logic [NUM_CNT-1:0]   cnt_inc_out
);
  import pesd_pkg::*;

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_q;
  logic rstn_q;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_q <= 1'b0;
      rstn_q     <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rstn_q     <= rst_meta_q;
    end
  end

  // ************************************************************
  // register state
  // ************************************************************
  pesd_word_t         evt_q [NUM_EVT];
  pesd_word_t         evt_d [NUM_EVT];
  pesd_word_t         cfg_q [NUM_CNT];
  pesd_word_t         cfg_d [NUM_CNT];
  pesd_word_t         cnt_q [NUM_CNT];
  pesd_word_t         cnt_d [NUM_CNT];
  pesd_word_t         rdata_q;
  pesd_word_t         rdata_d;
  logic [NUM_CNT-1:0] inc_q;
  logic [NUM_CNT-1:0] hit_w;

  logic [5:0] word_idx;
  logic       in_evt;
  logic       in_cfg;
  logic       in_cnt;
  logic [2:0] evt_idx;
  logic [1:0] sub_idx;

  assign word_idx = reg_addr_in[7:2];
  assign in_evt   = (reg_addr_in >= `PESD_OFS_EVT_BASE) &&
                    (reg_addr_in < (`PESD_OFS_EVT_BASE + 8'(4 * NUM_EVT)));
  assign in_cfg   = (reg_addr_in >= `PESD_OFS_CFG_BASE) &&
                    (reg_addr_in < (`PESD_OFS_CFG_BASE + 8'(4 * NUM_CNT)));
  assign in_cnt   = (reg_addr_in >= `PESD_OFS_CNT_BASE) &&
                    (reg_addr_in < (`PESD_OFS_CNT_BASE + 8'(4 * NUM_CNT)));
  assign evt_idx  = word_idx[2:0];
  assign sub_idx  = word_idx[1:0];

  // ************************************************************
  // event decode, one slice per counter
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_dec
      // pair half: counters 4,5 take the first register, 6,7 the second
      localparam int HALF = (gi < NUM_CNT / 2) ? 0 : 1;
      localparam int SEQ  = 0 + HALF;
      localparam int BR   = 2 + HALF;
      localparam int PWR  = 4 + HALF;

      logic [2:0] src;
      logic       en;
      logic [6:0] seq_code;
      logic [5:0] br_code;
      logic [6:0] pwr_code;
      logic [3:0] seq_mask;
      logic [4:0] br_mask;
      logic       pwr_mask;
      logic       hit;

      assign src      = cfg_q[gi][`PESD_CFG_SEL_HI:`PESD_CFG_SEL_LO];
      assign en       = cfg_q[gi][`PESD_CFG_EN_BIT];
      assign seq_code = evt_q[SEQ][`PESD_EVT_SEL7_HI:`PESD_EVT_SEL_LO];
      assign br_code  = evt_q[BR][`PESD_EVT_SEL6_HI:`PESD_EVT_SEL_LO];
      assign pwr_code = evt_q[PWR][`PESD_EVT_SEL7_HI:`PESD_EVT_SEL_LO];
      assign seq_mask = evt_q[SEQ][`PESD_EVT_MASK_LO +: 4];
      assign br_mask  = evt_q[BR][`PESD_EVT_MASK_LO +: 5];
      assign pwr_mask = evt_q[PWR][`PESD_EVT_MASK_LO];

      always_comb begin
        hit = 1'b0;
        unique case (src)
          PESD_SRC_SEQ: begin
            if (seq_code == `PESD_CODE_XFER) begin
              hit = seq_mask[0] & delivery_switch_event_in;
            end else if (seq_code == `PESD_CODE_QWRITE) begin
              // any set mask bit matching the write's source counts it
              hit = uopq_write_in & (|(seq_mask[2:0] & uopq_src_in));
            end
          end
          PESD_SRC_BR: begin
            // conditional mispredicts pass through as flagged, overcount included
            if (br_code == `PESD_CODE_MISPRED) begin
              hit = br_retire_in & br_mispred_in & (|(br_mask[4:1] & br_type_in));
            end else if (br_code == `PESD_CODE_RETIRED) begin
              hit = br_retire_in & (|(br_mask[4:1] & br_type_in));
            end
          end
          PESD_SRC_PWR: begin
            if (pwr_code == `PESD_CODE_ACTIVE) begin
              hit = pwr_mask & proc_active_in;
            end
          end
          default: hit = 1'b0;
        endcase
      end

      assign hit_w[gi] = en & hit;
    end
  endgenerate

  // ************************************************************
  // register and counter next state
  // ************************************************************
  always_comb begin
    for (int i = 0; i < NUM_EVT; i++) begin
      evt_d[i] = evt_q[i];
    end
    for (int i = 0; i < NUM_CNT; i++) begin
      cfg_d[i] = cfg_q[i];
      // a software load wins over a same-cycle increment
      cnt_d[i] = hit_w[i] ? cnt_q[i] + 32'h00000001 : cnt_q[i];
    end
    rdata_d = 32'h00000000;
    if (reg_wr_in) begin
      if (in_evt) begin
        evt_d[evt_idx] = reg_wdata_in & `PESD_EVT_WMASK;
      end else if (in_cfg) begin
        cfg_d[sub_idx] = reg_wdata_in & `PESD_CFG_WMASK;
      end else if (in_cnt) begin
        cnt_d[sub_idx] = reg_wdata_in;
      end
    end
    if (reg_rd_in) begin
      if (in_evt) begin
        rdata_d = evt_q[evt_idx];
      end else if (in_cfg) begin
        rdata_d = cfg_q[sub_idx];
      end else if (in_cnt) begin
        rdata_d = cnt_q[sub_idx];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_q) begin
    if (!rstn_q) begin
      for (int i = 0; i < NUM_EVT; i++) begin
        evt_q[i] <= `PESD_EVT_RESET;
      end
      for (int i = 0; i < NUM_CNT; i++) begin
        cfg_q[i] <= `PESD_CFG_RESET;
        cnt_q[i] <= `PESD_CNT_RESET;
      end
      rdata_q <= 32'h00000000;
      inc_q   <= '0;
    end else begin
      evt_q   <= evt_d;
      cfg_q   <= cfg_d;
      cnt_q   <= cnt_d;
      rdata_q <= rdata_d;
      inc_q   <= hit_w;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign cnt_inc_out   = inc_q;

endmodule
`default_nettype wire

//--- verification/pesd_asserts.sv
// port checker for pesd_top, bound below
// assumes one clock domain and the strobe register port
`timescale 1ns/100ps
`default_nettype none
module pesd_asserts #(parameter int NUM_CNT = 4) (
  input wire logic                 clk_sys_in,
  input wire logic                 rstn_in,
  input wire pesd_pkg::pesd_addr_t reg_addr_in,
  input wire pesd_pkg::pesd_word_t reg_wdata_in,
  input wire logic                 reg_wr_in,
  input wire logic                 reg_rd_in,
  input wire pesd_pkg::pesd_word_t reg_rdata_out,
  input wire logic                 proc_active_in,
  input wire logic                 delivery_switch_event_in,
  input wire logic                 uopq_write_in,
  input wire logic [2:0]           uopq_src_in,
  input wire logic                 br_retire_in,
  input wire logic                 br_mispred_in,
  input wire logic [3:0]           br_type_in,
  input wire logic [NUM_CNT-1:0]   cnt_inc_out
);
  import pesd_pkg::*;
  wire logic ev_fb = proc_active_in | delivery_switch_event_in;
  wire logic ev_any = ev_fb | uopq_write_in | br_retire_in;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence s_bad_rd; reg_rd_in && (reg_addr_in >= 8'h40 || reg_addr_in[7:3] == 5'h03); endsequence
  sequence s_cnt_wr; reg_wr_in && reg_addr_in[7:4] == 4'h3 && !ev_any; endsequence
  property p_rd_idle; !reg_rd_in |=> reg_rdata_out == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_bad; s_bad_rd |=> reg_rdata_out == '0; endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not zero");
  property p_evt_rsvd; reg_rd_in && reg_addr_in < 8'h18 |=> reg_rdata_out[8:0] == 9'h000; endproperty
  a_evt_rsvd: assert property (p_evt_rsvd) else $error("event reg low bits set");
  property p_cfg_rsvd; reg_rd_in && reg_addr_in[7:4] == 4'h2 |=> reg_rdata_out[31:16] == 16'h0000; endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config reg high bits set");
  property p_inc_cause; !ev_any |=> cnt_inc_out == '0; endproperty
  a_inc_cause: assert property (p_inc_cause) else $error("count without event");
  property p_q_nosrc; uopq_write_in && uopq_src_in == 3'h0 && !ev_fb && !br_retire_in |=> cnt_inc_out == '0;
  endproperty
  a_q_nosrc: assert property (p_q_nosrc) else $error("queue write without source counted");
  property p_br_notype; br_retire_in && br_type_in == 4'h0 && !ev_fb && !uopq_write_in |=> cnt_inc_out == '0;
  endproperty
  a_br_notype: assert property (p_br_notype) else $error("branch without type counted");
  property p_cnt_load; s_cnt_wr ##1 !ev_any ##1 (reg_rd_in && reg_addr_in == $past(reg_addr_in, 2) && !ev_any)
    |=> reg_rdata_out == $past(reg_wdata_in, 3); endproperty
  a_cnt_load: assert property (p_cnt_load) else $error("counter load not read back");
endmodule
bind pesd_top pesd_asserts #(.NUM_CNT(NUM_CNT)) u_chk (.*);
`default_nettype wire

//--- verification/pesd_src_model.sv
// pipeline event source model for the decoder
// assumes the bench calls ev() between its own bus tasks
`timescale 1ns/100ps
`default_nettype none
module pesd_src_model (
  input  wire logic       clk_sys_in,
  output var  logic       act_out,
  output var  logic       sw_out,
  output var  logic       qw_out,
  output var  logic [2:0] qs_out,
  output var  logic       br_out,
  output var  logic       mp_out,
  output var  logic [3:0] bt_out
);
  initial {act_out, sw_out, qw_out, qs_out, br_out, mp_out, bt_out} = 12'h000;
  // idle qualifiers flip so a stale source or type cannot pass for a live one
  task automatic ev(input logic [11:0] v, input int n);
    repeat (n) begin
      @(posedge clk_sys_in);
      {act_out, sw_out, qw_out, qs_out, br_out, mp_out, bt_out} <= v;
    end
    @(posedge clk_sys_in);
    {act_out, sw_out, qw_out, qs_out, br_out, mp_out, bt_out} <= {3'h0, ~v[8:6], 2'h0, ~v[3:0]};
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for pesd_top
// assumes the source model and checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pesd_pkg::*;
  logic       clk_sys_in = 1'b0;
  logic       rstn_in = 1'b0;
  pesd_addr_t reg_addr_in = 8'h00;
  pesd_word_t reg_wdata_in = 32'h0;
  logic       reg_wr_in = 1'b0;
  logic       reg_rd_in = 1'b0;
  pesd_word_t reg_rdata_out;
  logic       proc_active_in, delivery_switch_event_in, uopq_write_in, br_retire_in, br_mispred_in;
  logic [2:0] uopq_src_in;
  logic [3:0] br_type_in;
  logic [3:0] cnt_inc_out;
  int         n_errors = 0;
  int         tests_run = 0;
  int         cyc = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  pesd_top dut (.*);
  pesd_src_model u_src (.clk_sys_in, .act_out(proc_active_in), .sw_out(delivery_switch_event_in),
    .qw_out(uopq_write_in), .qs_out(uopq_src_in), .br_out(br_retire_in), .mp_out(br_mispred_in),
    .bt_out(br_type_in));
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic cmp(input pesd_word_t e, input pesd_word_t g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_inc(input logic [3:0] e, input logic [3:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input pesd_addr_t a, input pesd_word_t d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rc(input pesd_addr_t a, input pesd_word_t e);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_sys_in);
    cmp(e, reg_rdata_out);
  endtask
  // one event cycle, then the increment pulse in the cycle after it
  task automatic fire(input logic [11:0] v, input logic [3:0] e);
    u_src.ev(v, 1);
    @(negedge clk_sys_in);
    cmp_inc(e, cnt_inc_out);
  endtask
  task automatic t_switch();
    wr(8'h00, 32'h0a000200);
    wr(8'h20, 32'h00001000);
    fire(12'h400, 4'h1);
    u_src.ev(12'h400, 2);
    rc(8'h30, 32'h3);
    $display("switch test done");
  endtask
  task automatic t_queue();
    wr(8'h04, 32'h12000400);
    wr(8'h2c, 32'h00001000);
    fire(12'h280, 4'h8);
    fire(12'h240, 4'h0);
    fire(12'h200, 4'h0);
    wr(8'h04, 32'h12000a00);
    fire(12'h240, 4'h8);
    fire(12'h300, 4'h8);
    fire(12'h280, 4'h0);
    $display("queue test done");
  endtask
  task automatic t_branch();
    wr(8'h24, 32'h00005000);
    wr(8'h28, 32'h00005000);
    for (int k = 0; k < 4; k++) begin
      wr(8'h08, 32'h0a000000 | (32'h400 << k));
      wr(8'h0c, 32'h08000000 | (32'h400 << k));
      fire(12'h030 | (12'h1 << k), 4'h6);
      fire(12'h020 | (12'h1 << k), 4'h4);
      fire(12'h030 | (12'h1 << ((k + 1) % 4)), 4'h0);
    end
    fire(12'h020, 4'h0);
    $display("branch test done");
  endtask
  task automatic t_active();
    wr(8'h10, 32'h260003ff);
    rc(8'h10, 32'h26000200);
    wr(8'h20, 32'hffffd000);
    rc(8'h20, 32'h0000d000);
    wr(8'h30, 32'h000000f0);
    rc(8'h30, 32'h000000f0);
    u_src.ev(12'h800, 5);
    rc(8'h30, 32'h000000f5);
    wr(8'h40, 32'hffffffff);
    rc(8'h40, 32'h0);
    rc(8'h18, 32'h0);
    $display("active test done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    t_switch();
    t_queue();
    t_branch();
    t_active();
    conclude();
  end
endmodule
`default_nettype wire
